// *** hdl/ustrg_pkg.sv ***
package ustrg_pkg;

  // ********************************************************
  // register map (byte addresses)
  // ********************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HALFDIV = 8'h04;
  localparam logic [7:0] OFS_IDLE = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0c;
  localparam logic [7:0] OFS_SYMNUM = 8'h10;
  localparam logic [7:0] OFS_PLEN = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_TRIGCNT = 8'h1c;
  localparam logic [3:0] PAT_PAGE = 4'h2;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CTRL_SRC = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_PAR = 4;
  localparam int CTRL_WLEN = 6;
  localparam int CTRL_STOP = 10;
  localparam int PAT_CARE = 16;
  localparam int STAT_STATE = 0;
  localparam int STAT_INFRAME = 3;
  localparam int STAT_SYMIDX = 4;
  localparam int STAT_FSTATE = 16;

  // ********************************************************
  // reset values and limits
  // ********************************************************
  localparam logic [3:0] WLEN_MIN = 4'h5;
  localparam logic [3:0] WLEN_MAX = 4'h9;
  localparam logic [3:0] WLEN_RST = 4'h8;
  localparam logic [15:0] HALFDIV_RST = 16'h000a;
  localparam logic [15:0] IDLE_RST = 16'h000a;
  localparam logic [2:0] PLEN_MIN = 3'h1;
  localparam logic [2:0] PLEN_MAX = 3'h4;
  localparam logic [11:0] SYM_MAX = 12'hfff;
  localparam logic [16:0] IDLE_SAT = 17'h1ffff;

  // ********************************************************
  // timing in half-bit ticks
  // ********************************************************
  localparam logic [4:0] HB_CENTRE = 5'h01;
  localparam logic [4:0] HB_BIT = 5'h02;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    M_START = 3'b000, M_FRAME = 3'b001, M_FERR = 3'b010,
    M_SYMBOL = 3'b011, M_BREAK = 3'b100, M_PERR = 3'b101,
    M_PATTERN = 3'b110, M_ANY = 3'b111
  } ustrg_mode_e;

  typedef enum logic [1:0] {
    P_NONE = 2'b00, P_EVEN = 2'b01, P_ODD = 2'b10
  } ustrg_par_e;

  typedef enum logic [1:0] {
    S_ONE = 2'b00, S_ONEHALF = 2'b01, S_TWO = 2'b10
  } ustrg_stop_e;

  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
    R_PAR = 3'b011, R_STOP = 3'b100, R_STOP2 = 3'b101,
    R_WAITHI = 3'b110, R_BRK = 3'b111
  } ustrg_rx_e;

  typedef struct packed {
    logic src;
    ustrg_mode_e mode;
    ustrg_par_e par;
    logic [3:0] wlen;
    ustrg_stop_e stop;
    logic [15:0] halfdiv;
    logic [15:0] idle;
    logic [11:0] offset;
    logic [11:0] symnum;
    logic [2:0] plen;
    logic [3:0][8:0] pval;
    logic [3:0][8:0] pcare;
  } ustrg_cfg_s;

endpackage

// *** hdl/ustrg_top.sv ***
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - input is transmit or receive line, chosen by source select
// - start-bit mode fires on first low bit after a stop bit
// - frame-start mode fires on first start bit after idle time
// - frame-error mode fires when the stop bit is missing
// - break mode fires when line stays low beyond one word time
// - parity-error mode fires when parity bit disagrees with data
// - pattern mode matches consecutive symbols from the set position
// - any-symbol mode fires on first symbol matching one-symbol pattern
// - symbol offset 0 to 4095 leading symbols are skipped
// - comparison starts at the symbol right after the offset
// - pattern length selects one to four symbols
// - pattern bits beyond length raise the length automatically
// - pattern bits are 0, 1 or don't care, excluded from compare
// - pattern only matters in pattern and any-symbol modes
// - each frame yields a record: start time, data words, state
// - parity none, even or odd over data plus parity bit
// - word length five to nine data bits
// - stop bits one, one and a half or two; one and a half is checked like two
// - start bit after minimum idle gap begins a new frame
module ustrg_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ustrg_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_LINE,
  input wire logic RX_LINE,
  output logic TRIG,
  output logic SYM_VALID,
  output logic [8:0] SYM_DATA,
  output logic FRAME_VALID,
  output logic [31:0] FRAME_TIME,
  output logic [1:0] FRAME_STATE
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    ustrg_pkg::ustrg_cfg_s cfg;
    ustrg_pkg::ustrg_rx_e st;
    logic [15:0] cnt;
    logic [4:0] hb;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic all_low;
    logic [16:0] idle_cnt;
    logic in_frame;
    logic [11:0] sym_idx;
    logic pat_ok;
    logic any_done;
    logic [31:0] ts;
    logic [31:0] trig_ts;
    logic [31:0] fstart_ts;
    logic [1:0] fstate;
    logic [15:0] trig_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic trig;
    logic sym_valid;
    logic [8:0] sym_data;
    logic frame_valid;
    logic [31:0] frame_time;
    logic [1:0] frame_state;
  } ustrg_state_s;

  ustrg_state_s s;
  ustrg_state_s next_s;
  logic line;
  logic tick;
  logic [15:0] hd;
  logic word_done;
  logic [7:0] hit;
  logic [12:0] pos;
  logic [31:0] rdat;
  logic rerr;
  logic [1:0] pi;
  logic [3:0] w;
  logic [2:0] pl;

  function automatic logic sym_match(input logic [8:0] v,
                                     input logic [8:0] val,
                                     input logic [8:0] care);
    sym_match = ((v ^ val) & care) == 9'h000;
  endfunction

  function automatic logic at_hb(input logic t, input logic [4:0] h,
                                 input logic [4:0] tgt);
    at_hb = t && (h == tgt - 5'h01);
  endfunction

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    next_s = s;
    word_done = 1'b0;
    hit = 8'h00;
    pos = 13'h0000;
    pi = 2'b00;
    rdat = 32'h0000_0000;
    rerr = 1'b0;
    w = 4'h0;
    pl = 3'h0;
    next_s.trig = 1'b0;
    next_s.sym_valid = 1'b0;
    next_s.frame_valid = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.ts = s.ts + 32'h0000_0001;
    line = s.cfg.src ? RX_LINE : TX_LINE;
    // half-bit timer; divisor 0 behaves as 1
    hd = (s.cfg.halfdiv == 16'h0000) ? 16'h0001 : s.cfg.halfdiv;
    tick = (s.cnt >= hd - 16'h0001);
    next_s.cnt = tick ? 16'h0000 : s.cnt + 16'h0001;
    if (tick) begin
      next_s.hb = s.hb + 5'h01;
    end

    case (s.st)
      ustrg_pkg::R_IDLE: begin
        if (tick && s.idle_cnt != ustrg_pkg::IDLE_SAT) begin
          next_s.idle_cnt = s.idle_cnt + 17'h00001;
        end
        // close the frame once the gap reaches the idle time
        if (s.in_frame && s.idle_cnt >= {s.cfg.idle, 1'b0}) begin
          next_s.in_frame = 1'b0;
          next_s.frame_valid = 1'b1;
          next_s.frame_time = s.fstart_ts - s.trig_ts;
          next_s.frame_state = s.fstate;
        end
        if (!line) begin
          next_s.st = ustrg_pkg::R_START;
          next_s.cnt = 16'h0000;
          next_s.hb = 5'h00;
        end
      end
      ustrg_pkg::R_START: begin
        if (at_hb(tick, s.hb, ustrg_pkg::HB_CENTRE)) begin
          if (line) begin
            // glitch shorter than half a bit is not a start bit
            next_s.st = ustrg_pkg::R_IDLE;
          end else begin
            hit[ustrg_pkg::M_START] = 1'b1;
            if (!s.in_frame || s.idle_cnt >= {s.cfg.idle, 1'b0}) begin
              hit[ustrg_pkg::M_FRAME] = 1'b1;
              next_s.in_frame = 1'b1;
              next_s.sym_idx = 12'h000;
              next_s.fstart_ts = s.ts;
              next_s.fstate = 2'b00;
              next_s.pat_ok = 1'b1;
              next_s.any_done = 1'b0;
            end
            next_s.idle_cnt = 17'h00000;
            next_s.st = ustrg_pkg::R_DATA;
            next_s.hb = 5'h00;
            next_s.bitn = 4'h0;
            next_s.shreg = 9'h000;
            next_s.all_low = 1'b1;
          end
        end
      end
      ustrg_pkg::R_DATA: begin
        if (at_hb(tick, s.hb, ustrg_pkg::HB_BIT)) begin
          next_s.hb = 5'h00;
          next_s.shreg[s.bitn] = line;
          next_s.all_low = s.all_low & ~line;
          next_s.bitn = s.bitn + 4'h1;
          if (s.bitn == s.cfg.wlen - 4'h1) begin
            next_s.st = (s.cfg.par == ustrg_pkg::P_NONE) ?
                        ustrg_pkg::R_STOP : ustrg_pkg::R_PAR;
          end
        end
      end
      ustrg_pkg::R_PAR: begin
        if (at_hb(tick, s.hb, ustrg_pkg::HB_BIT)) begin
          next_s.hb = 5'h00;
          next_s.all_low = s.all_low & ~line;
          next_s.st = ustrg_pkg::R_STOP;
          // even: ones in data plus parity even; odd: odd
          if ((^s.shreg ^ line) != (s.cfg.par == ustrg_pkg::P_ODD)) begin
            hit[ustrg_pkg::M_PERR] = 1'b1;
            next_s.fstate[1] = 1'b1;
          end
        end
      end
      ustrg_pkg::R_STOP: begin
        if (at_hb(tick, s.hb, ustrg_pkg::HB_BIT)) begin
          next_s.hb = 5'h00;
          word_done = 1'b1;
          if (line) begin
            next_s.st = (s.cfg.stop == ustrg_pkg::S_ONE) ?
                        ustrg_pkg::R_IDLE : ustrg_pkg::R_STOP2;
          end else begin
            hit[ustrg_pkg::M_FERR] = 1'b1;
            next_s.fstate[0] = 1'b1;
            next_s.st = s.all_low ? ustrg_pkg::R_BRK : ustrg_pkg::R_WAITHI;
          end
        end
      end
      ustrg_pkg::R_STOP2: begin
        // second stop bit (or the extra half) sampled one full bit after the first stop centre
        if (at_hb(tick, s.hb, ustrg_pkg::HB_BIT)) begin
          next_s.hb = 5'h00;
          if (line) begin
            next_s.st = ustrg_pkg::R_IDLE;
          end else begin
            hit[ustrg_pkg::M_FERR] = 1'b1;
            next_s.fstate[0] = 1'b1;
            next_s.st = ustrg_pkg::R_WAITHI;
          end
        end
      end
      ustrg_pkg::R_BRK: begin
        if (line) begin
          next_s.st = ustrg_pkg::R_IDLE;
        end else if (at_hb(tick, s.hb, ustrg_pkg::HB_CENTRE)) begin
          // stop centre plus half a bit ends a full word time low
          hit[ustrg_pkg::M_BREAK] = 1'b1;
          next_s.st = ustrg_pkg::R_WAITHI;
        end
      end
      ustrg_pkg::R_WAITHI: begin
        if (line) begin
          next_s.st = ustrg_pkg::R_IDLE;
        end
      end
      default: begin
        next_s.st = ustrg_pkg::R_IDLE;
      end
    endcase

    // ********************************************************
    // symbol conditions
    // ********************************************************
    if (word_done) begin
      next_s.sym_valid = 1'b1;
      next_s.sym_data = s.shreg;
      if (s.sym_idx != ustrg_pkg::SYM_MAX) begin
        next_s.sym_idx = s.sym_idx + 12'h001;
      end
      if (s.sym_idx == s.cfg.symnum) begin
        hit[ustrg_pkg::M_SYMBOL] = 1'b1;
      end
      pos = {1'b0, s.sym_idx} - {1'b0, s.cfg.offset};
      pi = pos[1:0];
      if (s.sym_idx >= s.cfg.offset && pos < {10'h000, s.cfg.plen}) begin
        // first compared symbol is the one right after the offset
        next_s.pat_ok = ((pos == 13'h0000) | s.pat_ok) &
                        sym_match(s.shreg, s.cfg.pval[pi],
                                  s.cfg.pcare[pi]);
        if (pos == {10'h000, s.cfg.plen - 3'h1} && next_s.pat_ok) begin
          hit[ustrg_pkg::M_PATTERN] = 1'b1;
        end
      end
      if (!s.any_done &&
          sym_match(s.shreg, s.cfg.pval[0], s.cfg.pcare[0])) begin
        hit[ustrg_pkg::M_ANY] = 1'b1;
        next_s.any_done = 1'b1;
      end
    end

    // only the selected condition reaches the output
    if (hit[s.cfg.mode]) begin
      next_s.trig = 1'b1;
      next_s.trig_ts = s.ts;
      next_s.trig_cnt = s.trig_cnt + 16'h0001;
    end

    // ********************************************************
    // register bus
    // ********************************************************
    case (PADDR)
      ustrg_pkg::OFS_CTRL: begin
        rdat[ustrg_pkg::CTRL_SRC] = s.cfg.src;
        rdat[ustrg_pkg::CTRL_MODE +: 3] = s.cfg.mode;
        rdat[ustrg_pkg::CTRL_PAR +: 2] = s.cfg.par;
        rdat[ustrg_pkg::CTRL_WLEN +: 4] = s.cfg.wlen;
        rdat[ustrg_pkg::CTRL_STOP +: 2] = s.cfg.stop;
      end
      ustrg_pkg::OFS_HALFDIV: rdat[15:0] = s.cfg.halfdiv;
      ustrg_pkg::OFS_IDLE: rdat[15:0] = s.cfg.idle;
      ustrg_pkg::OFS_OFFSET: rdat[11:0] = s.cfg.offset;
      ustrg_pkg::OFS_SYMNUM: rdat[11:0] = s.cfg.symnum;
      ustrg_pkg::OFS_PLEN: rdat[2:0] = s.cfg.plen;
      ustrg_pkg::OFS_STATUS: begin
        rdat[ustrg_pkg::STAT_STATE +: 3] = s.st;
        rdat[ustrg_pkg::STAT_INFRAME] = s.in_frame;
        rdat[ustrg_pkg::STAT_SYMIDX +: 12] = s.sym_idx;
        rdat[ustrg_pkg::STAT_FSTATE +: 2] = s.fstate;
      end
      ustrg_pkg::OFS_TRIGCNT: rdat[15:0] = s.trig_cnt;
      default: begin
        if (PADDR[7:4] == ustrg_pkg::PAT_PAGE && PADDR[1:0] == 2'b00) begin
          rdat[8:0] = s.cfg.pval[PADDR[3:2]];
          rdat[ustrg_pkg::PAT_CARE +: 9] = s.cfg.pcare[PADDR[3:2]];
        end else begin
          rerr = 1'b1;
        end
      end
    endcase
    if (PSEL && !PENABLE) begin
      next_s.pready = 1'b1;
      next_s.pslverr = rerr;
      next_s.prdata = rerr ? 32'h0000_0000 : rdat;
    end
    if (PSEL && PENABLE && s.pready && PWRITE && !rerr) begin
      case (PADDR)
        ustrg_pkg::OFS_CTRL: begin
          next_s.cfg.src = PWDATA[ustrg_pkg::CTRL_SRC];
          next_s.cfg.mode =
            ustrg_pkg::ustrg_mode_e'(PWDATA[ustrg_pkg::CTRL_MODE +: 3]);
          next_s.cfg.par = (PWDATA[ustrg_pkg::CTRL_PAR +: 2] == 2'b11) ?
            ustrg_pkg::P_NONE :
            ustrg_pkg::ustrg_par_e'(PWDATA[ustrg_pkg::CTRL_PAR +: 2]);
          w = PWDATA[ustrg_pkg::CTRL_WLEN +: 4];
          next_s.cfg.wlen = (w < ustrg_pkg::WLEN_MIN) ? ustrg_pkg::WLEN_MIN :
            (w > ustrg_pkg::WLEN_MAX) ? ustrg_pkg::WLEN_MAX : w;
          next_s.cfg.stop = (PWDATA[ustrg_pkg::CTRL_STOP +: 2] == 2'b11) ?
            ustrg_pkg::S_TWO :
            ustrg_pkg::ustrg_stop_e'(PWDATA[ustrg_pkg::CTRL_STOP +: 2]);
        end
        ustrg_pkg::OFS_HALFDIV: next_s.cfg.halfdiv = PWDATA[15:0];
        ustrg_pkg::OFS_IDLE: next_s.cfg.idle = PWDATA[15:0];
        ustrg_pkg::OFS_OFFSET: next_s.cfg.offset = PWDATA[11:0];
        ustrg_pkg::OFS_SYMNUM: next_s.cfg.symnum = PWDATA[11:0];
        ustrg_pkg::OFS_PLEN: begin
          pl = PWDATA[2:0];
          next_s.cfg.plen = (pl < ustrg_pkg::PLEN_MIN) ? ustrg_pkg::PLEN_MIN :
            (pl > ustrg_pkg::PLEN_MAX) ? ustrg_pkg::PLEN_MAX : pl;
        end
        ustrg_pkg::OFS_STATUS, ustrg_pkg::OFS_TRIGCNT: begin
          next_s.cfg = s.cfg;
        end
        default: begin
          next_s.cfg.pval[PADDR[3:2]] = PWDATA[8:0];
          next_s.cfg.pcare[PADDR[3:2]] = PWDATA[ustrg_pkg::PAT_CARE +: 9];
          // a specified bit beyond the length stretches the length
          if (PWDATA[ustrg_pkg::PAT_CARE +: 9] != 9'h000 &&
              {1'b0, PADDR[3:2]} >= s.cfg.plen) begin
            next_s.cfg.plen = {1'b0, PADDR[3:2]} + 3'h1;
          end
        end
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s <= '0;
      s.cfg.wlen <= ustrg_pkg::WLEN_RST;
      s.cfg.halfdiv <= ustrg_pkg::HALFDIV_RST;
      s.cfg.idle <= ustrg_pkg::IDLE_RST;
      s.cfg.plen <= ustrg_pkg::PLEN_MIN;
      s.idle_cnt <= ustrg_pkg::IDLE_SAT;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign TRIG = s.trig;
  assign SYM_VALID = s.sym_valid;
  assign SYM_DATA = s.sym_data;
  assign FRAME_VALID = s.frame_valid;
  assign FRAME_TIME = s.frame_time;
  assign FRAME_STATE = s.frame_state;

endmodule

// *** sim/ustrg_props.sv ***
`timescale 1ns/1ns
// ****************
// port checker
// ****************
module ustrg_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRIG,
  input wire logic SYM_VALID,
  input wire logic [8:0] SYM_DATA,
  input wire logic FRAME_VALID,
  input wire logic [31:0] FRAME_TIME
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_rdy_setup;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup)
    else $error("no ready after setup");
  property p_rdy_cause;
    PREADY |-> $past(PSEL) && !$past(PENABLE);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("ready without setup");
  property p_err_zero;
    PSLVERR |-> PREADY && PRDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error reply not clean");
  // the shortest legal word is 14 cycles, so 8 quiet cycles are safe
  property p_trig_gap;
    TRIG |=> !TRIG [*8];
  endproperty
  a_trig_gap: assert property (p_trig_gap)
    else $error("trigger longer than a pulse");
  property p_sym_gap;
    SYM_VALID |=> !SYM_VALID [*8];
  endproperty
  a_sym_gap: assert property (p_sym_gap)
    else $error("symbols too close");
  property p_frame_gap;
    FRAME_VALID |-> !SYM_VALID ##1 !FRAME_VALID [*8];
  endproperty
  a_frame_gap: assert property (p_frame_gap)
    else $error("frame close misplaced");
  property p_sym_hold;
    $changed(SYM_DATA) |-> SYM_VALID;
  endproperty
  a_sym_hold: assert property (p_sym_hold)
    else $error("symbol data moved alone");
  property p_ftime_hold;
    $changed(FRAME_TIME) |-> FRAME_VALID;
  endproperty
  a_ftime_hold: assert property (p_ftime_hold)
    else $error("frame time moved alone");
endmodule

bind ustrg_top ustrg_chk ustrg_chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TRIG(TRIG), .SYM_VALID(SYM_VALID),
  .SYM_DATA(SYM_DATA), .FRAME_VALID(FRAME_VALID),
  .FRAME_TIME(FRAME_TIME));

// *** sim/ustrg_line_model.sv ***
`timescale 1ns/1ns
// ****************
// serial transmitter model
// ****************
module ustrg_line_model #(
  parameter int BT = 20
) (
  input wire logic clk,
  output logic tx_line,
  output logic rx_line
);
  logic sel = 1'b0;
  logic lvl = 1'b1;
  // the line not in use rests at its idle high level
  assign tx_line = sel ? 1'b1 : lvl;
  assign rx_line = sel ? lvl : 1'b1;
  task automatic bit_out(input logic b);
    lvl <= b;
    repeat (BT) @(posedge clk);
  endtask
  // par: 0 none, 1 even fill, 2 odd fill
  task automatic word(input logic s, input logic [8:0] d, input int n,
                      input int par, input logic ok);
    logic p;
    p = ^(d & (9'h1ff >> (9 - n)));
    sel <= s;
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (par != 0) bit_out(par == 1 ? p : ~p);
    bit_out(ok);
    bit_out(ok);
    bit_out(1'b1);
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, FRAME_TIME;
  logic PREADY, PSLVERR, TX_LINE, RX_LINE, TRIG, SYM_VALID, FRAME_VALID;
  logic [8:0] SYM_DATA;
  logic [1:0] FRAME_STATE;
  logic [32:0] rq[$];
  logic [8:0] sq[$];
  logic [34:0] fq[$];
  logic [34:0] fe;
  int num_errors = 0;
  int checked = 0;
  int ntrig = 0;
  int nframe = 0;
  int cyc = 0;
  integer seed = 32'he729b8f4;
  logic chk_sym = 1'b0;
  logic src_sel;
  logic [8:0] frame_a[4] = '{9'h011, 9'h05a, 9'h0c3, 9'h03c};
  int exp_a[8] = '{4, 1, 0, 1, 0, 0, 1, 1};
  logic [2:0] modes_b[5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  int exp_b[5] = '{2, 1, 1, 0, 0};

  always #25 REF_CLK = ~REF_CLK;

  ustrg_top ustrg_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_LINE(TX_LINE), .RX_LINE(RX_LINE), .TRIG(TRIG),
    .SYM_VALID(SYM_VALID), .SYM_DATA(SYM_DATA),
    .FRAME_VALID(FRAME_VALID), .FRAME_TIME(FRAME_TIME),
    .FRAME_STATE(FRAME_STATE));
  ustrg_line_model #(.BT(20)) ustrg_line_model_i (.clk(REF_CLK),
    .tx_line(TX_LINE), .rx_line(RX_LINE));

  // ****************
  // checking and closing
  // ****************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // drivers
  // ****************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input logic s, input logic [2:0] m,
                     input logic [1:0] p, input logic [3:0] wl,
                     input logic [1:0] st);
    apb(1'b1, ustrg_pkg::OFS_CTRL, {20'h0, st, wl, p, m, s});
  endtask
  task automatic send(input logic s, input logic [8:0] d, input int n,
                      input int par, input logic ok);
    if (chk_sym) sq.push_back(d & (9'h1ff >> (9 - n)));
    ustrg_line_model_i.word(s, d, n, par, ok);
  endtask
  // long enough for the idle gap to close the frame
  task automatic idle_then(input int e);
    repeat (300) @(posedge REF_CLK);
    check(33'(ntrig), 33'(e));
    ntrig = 0;
  endtask

  // ****************
  // monitor
  // ****************
  always @(posedge REF_CLK) begin
    cyc++;
    if (TRIG === 1'b1) ntrig++;
    if (FRAME_VALID === 1'b1) begin
      nframe++;
      fe = fq.pop_front();
      check({31'h0, FRAME_STATE}, {31'h0, fe[33:32]});
      if (fe[34] === 1'b1) begin
        check({1'b0, FRAME_TIME}, {1'b0, fe[31:0]});
      end
    end
    if (SYM_VALID === 1'b1 && chk_sym) begin
      check({24'h0, SYM_DATA}, {24'h0, sq.pop_front()});
    end
    if (PREADY === 1'b1 && PWRITE === 1'b0) begin
      check({PSLVERR, PRDATA}, rq.pop_front());
    end
    // timeout last, so nothing runs after the closing report
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(ustrg_pkg::OFS_CTRL, 33'h200);
    rd(ustrg_pkg::OFS_HALFDIV, 33'h00a);
    rd(8'h40, {1'b1, 32'h0});
    apb(1'b1, ustrg_pkg::OFS_OFFSET, 32'h1);
    apb(1'b1, ustrg_pkg::OFS_SYMNUM, 32'h2);
    apb(1'b1, {ustrg_pkg::PAT_PAGE, 4'h0}, 32'h00f0_0050);
    apb(1'b1, {ustrg_pkg::PAT_PAGE, 4'h4}, 32'h01ff_00c3);
    rd(ustrg_pkg::OFS_PLEN, 33'h2);
    chk_sym = 1'b1;
    for (int m = 0; m < 8; m++) begin
      src_sel = 1'($random(seed));
      cfg(src_sel, 3'(m), 2'h1, 4'h8, 2'h0);
      for (int i = 0; i < 4; i++) send(src_sel, frame_a[i], 8, 1, 1'b1);
      // words are 260 cycles apart: start mode ends 3 words after start
      fq.push_back({1'(m < 2), 2'b00,
                    (m == 0) ? 32'hffff_fcf4 : 32'h0000_0000});
      idle_then(exp_a[m]);
    end
    check(33'(nframe), 33'h8);
    chk_sym = 1'b0;
    cfg(1'b0, 3'h0, 2'h1, 4'h8, 2'h0);
    send(1'b1, 9'h05a, 8, 1, 1'b1);
    idle_then(0);
    // bad parity, missing stop, then a held-low break word
    for (int k = 0; k < 5; k++) begin
      cfg(1'b0, modes_b[k], 2'h1, 4'h8, 2'h1);
      send(1'b0, 9'h033, 8, 2, 1'b1);
      send(1'b0, 9'h00f, 8, 1, 1'b0);
      send(1'b0, 9'h000, 8, 1, 1'b0);
      fq.push_back({1'b0, 2'b11, 32'h0000_0000});
      idle_then(exp_b[k]);
    end
    cfg(1'b1, 3'h5, 2'h2, 4'h5, 2'h2);
    chk_sym = 1'b1;
    for (int i = 0; i < 4; i++) send(1'b1, 9'($random(seed)), 5, 2, 1'b1);
    chk_sym = 1'b0;
    send(1'b1, 9'h015, 5, 1, 1'b1);
    fq.push_back({1'b0, 2'b10, 32'h0000_0000});
    idle_then(1);
    check(33'(sq.size()), 33'h0);
    check(33'(fq.size()), 33'h0);
    rd(ustrg_pkg::OFS_TRIGCNT, 33'h00d);
    // let the monitor take the last read before closing
    repeat (2) @(posedge REF_CLK);
    tally_and_finish();
  end
endmodule
